// ---- design/level_irq_cfg.svh ----
`ifndef LEVEL_IRQ_CFG_SVH
`define LEVEL_IRQ_CFG_SVH

// Register offsets
`define ADDR_REQ_STATUS 8'hDC
`define ADDR_LEVEL_MASK 8'hDD
`define ADDR_SYS_MODE 8'hDE
`define ADDR_LEVEL_PRIO 8'hFF

// System mode field positions
`define MODE_GLOBAL_EN 0
`define MODE_FAST_EN 1
`define MODE_FAST_LO 2
`define MODE_FAST_HI 4
`define MODE_EXT_IF 7
`define MODE_USED_MASK 8'h9F

// Priority field positions
`define PRIO_GRP_LO 1
`define PRIO_LVL01 0
`define PRIO_B_OUTER 2
`define PRIO_B_SUB 3
`define PRIO_GRP_MID 4
`define PRIO_C_ORDER 5
`define PRIO_GRP_HI 7

// Reset values
`define RST_BYTE 8'h00
`define RST_HW_PEND 4'h0

// Hardware-cleared source slots (equal to their level)
`define HW_T0_OVF 0
`define HW_T1_OVF 1
`define HW_CNT_A 2
`define HW_T2_OVF 3

// Source index of an overflow or a match inside its level
`define SRC_OVF 2'h0
`define SRC_MATCH 2'h1

// Group codes
`define GRP_A 2'h0
`define GRP_B 2'h1
`define GRP_C 2'h2

`endif

// ---- design/level_irq_pkg.sv ----
package level_irq_pkg;

	typedef struct packed {
		logic sel;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic enable_interrupts_instr;
		logic disable_interrupts_instr;
		logic interrupt_return_instr;
		logic ack;
	} cpu_ctl_t;

	typedef struct packed {
		logic [2:0] tmr_match;
		logic [7:0] port2;
		logic [7:0] port0;
	} sw_src_t;

	typedef struct packed {
		logic valid;
		logic fast;
		logic [2:0] level;
		logic [1:0] source;
	} irq_out_t;

	typedef struct packed {
		logic [7:0] level_mask;
		logic [7:0] system_mode_ctrl;
		logic [7:0] level_priority_ctrl;
		logic [7:0] level_request_status;
		logic [3:0] hw_pend;
		logic [7:0] rdata;
		irq_out_t irq;
	} lic_state_t;

endpackage

// ---- design/level_interrupt_controller.sv ----
// Behaviour
// R1: Timers, counter A and port nibbles map onto levels 0 to 7.
// R2: Overflow pendings cleared by hardware; match pendings kept in timers.
// R3: Software should disable interrupts before writing unmasked pending/enable.
// R4: Reset clears system mode bits 7, 1 and 0.
// R5: System mode bits 4..2 select the fast-interrupt level.
// R6: Bit 0 is global enable: enable/disable instructions and writes.
// R7: Init code must execute enable-interrupts; instructions preferred.
// R8: Mask bit n: 0 masks level n, 1 enables; read/write.
// R9: Software must initialise every mask bit.
// R10: Software must initialise every priority bit.
// R11: Highest-priority level wins; lowest vector wins inside a level.
// R12: Groups: A = levels 0,1; B = 2,3,4; C = 5,6,7.
// R13: Priority bits 7,4,1 order groups; 001 B>C>A, 101 C>B>A.
// R14: Priority bit 5 orders levels inside group C.
// R15: Bit 3 orders subgroup 3/4; bit 2 orders level 2 vs subgroup.
// R16: Priority bit 0 orders levels 0 and 1.
// R17: Status bit n is 1 while level n has a request.
// R18: Status is read-only, any time, and resets to zero.
// R19: With global enable clear, requests latch and show but are not served.
// R20: Pendings cleared by hardware on acknowledge, or by service software.
// R21: Serve only if enabled, unmasked, highest priority and source enabled.
// R22: Interrupt return sets global enable back to 1.
// R23: Fast processing applies only while system mode bit 1 is set.
// R24: Timer overflows and counter A cleared by hardware; others by software.
// R25: Resolver presents one winning level, with valid only while an unmasked request exists.
`timescale 1ns/100ps
`default_nettype none
`include "level_irq_cfg.svh"

module level_interrupt_controller
	import level_irq_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Register port
	input wire reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	// CPU core
	input wire cpu_ctl_t cpu_ctl,
	output irq_out_t irq,
	// Hardware-cleared sources: event pulses and enables
	input wire logic [3:0] hw_event,
	input wire logic [3:0] hw_enable,
	// Software-cleared sources: pending levels and enables
	input wire sw_src_t sw_pend,
	input wire sw_src_t sw_enable
);

	lic_state_t st_reg;
	lic_state_t st_next;
	logic [7:0] level_req;
	logic [7:0] serve_req;
	logic [3:0] win;
	sw_src_t sw_act;
	logic [3:0] hw_act;

	// Lowest index of four active lines
	function automatic logic [1:0] low4(input logic [3:0] v);
		logic [1:0] r;
		r = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (v[i]) begin
				r = 2'(i);
			end
		end
		return r;
	endfunction

	// Group order for priority bits 7,4,1: three group codes, first wins
	function automatic logic [5:0] group_order(input logic [2:0] code);
		logic [5:0] r;
		case (code)
			3'h1: r = {`GRP_B, `GRP_C, `GRP_A};
			3'h2: r = {`GRP_A, `GRP_C, `GRP_B};
			3'h3: r = {`GRP_B, `GRP_A, `GRP_C};
			3'h4: r = {`GRP_C, `GRP_A, `GRP_B};
			3'h5: r = {`GRP_C, `GRP_B, `GRP_A};
			default: r = {`GRP_A, `GRP_B, `GRP_C};
		endcase
		return r;
	endfunction

	// Winner {valid, level} among requesting levels
	function automatic logic [3:0] resolve(input logic [7:0] rq,
		input logic [7:0] pr);
		logic [3:0] wa;
		logic [3:0] wb;
		logic [3:0] wc;
		logic [3:0] wsub;
		logic [5:0] ord;
		logic [1:0] g;
		logic [3:0] r;
		// Group A
		if (pr[`PRIO_LVL01]) begin // [R16]
			wa = rq[1] ? 4'h9 : (rq[0] ? 4'h8 : 4'h0);
		end else begin
			wa = rq[0] ? 4'h8 : (rq[1] ? 4'h9 : 4'h0);
		end
		// Group B with subgroup of levels 3 and 4
		if (pr[`PRIO_B_SUB]) begin // [R15]
			wsub = rq[4] ? 4'hC : (rq[3] ? 4'hB : 4'h0);
		end else begin
			wsub = rq[3] ? 4'hB : (rq[4] ? 4'hC : 4'h0);
		end
		if (pr[`PRIO_B_OUTER]) begin // [R15]
			wb = wsub[3] ? wsub : (rq[2] ? 4'hA : 4'h0);
		end else begin
			wb = rq[2] ? 4'hA : wsub;
		end
		// Group C
		if (pr[`PRIO_C_ORDER]) begin // [R14]
			wc = rq[7] ? 4'hF : (rq[6] ? 4'hE : (rq[5] ? 4'hD : 4'h0));
		end else begin
			wc = rq[5] ? 4'hD : (rq[6] ? 4'hE : (rq[7] ? 4'hF : 4'h0));
		end
		// Groups in programmed order [R12] [R13]
		ord = group_order({pr[`PRIO_GRP_HI], pr[`PRIO_GRP_MID],
			pr[`PRIO_GRP_LO]});
		r = 4'h0;
		for (int i = 0; i < 3; i++) begin
			g = ord[4 - 2 * i +: 2];
			if (!r[3]) begin
				case (g)
					`GRP_A: r = wa;
					`GRP_B: r = wb;
					default: r = wc;
				endcase
			end
		end
		return r;
	endfunction

	// Source index inside a level, lowest vector first
	function automatic logic [1:0] source_of(input logic [2:0] lvl,
		input logic [3:0] hw, input sw_src_t sw);
		logic [1:0] r;
		case (lvl)
			3'h0: r = hw[`HW_T0_OVF] ? `SRC_OVF : `SRC_MATCH;
			3'h1: r = hw[`HW_T1_OVF] ? `SRC_OVF : `SRC_MATCH;
			3'h3: r = hw[`HW_T2_OVF] ? `SRC_OVF : `SRC_MATCH;
			3'h4: r = low4(sw.port2[3:0]);
			3'h5: r = low4(sw.port2[7:4]);
			3'h6: r = low4(sw.port0[3:0]);
			3'h7: r = low4(sw.port0[7:4]);
			default: r = `SRC_OVF;
		endcase
		return r;
	endfunction

	// Source-enabled requests gathered per level
	always_comb begin
		sw_act = sw_pend & sw_enable;
		hw_act = st_reg.hw_pend & hw_enable; // [R21]
		level_req[0] = hw_act[`HW_T0_OVF] | sw_act.tmr_match[0]; // [R1]
		level_req[1] = hw_act[`HW_T1_OVF] | sw_act.tmr_match[1]; // [R1]
		level_req[2] = hw_act[`HW_CNT_A]; // [R1]
		level_req[3] = hw_act[`HW_T2_OVF] | sw_act.tmr_match[2]; // [R1]
		level_req[4] = |sw_act.port2[3:0]; // [R1]
		level_req[5] = |sw_act.port2[7:4]; // [R1]
		level_req[6] = |sw_act.port0[3:0]; // [R1]
		level_req[7] = |sw_act.port0[7:4]; // [R1]
		serve_req = level_req & st_reg.level_mask; // [R8]
		win = resolve(serve_req, st_reg.level_priority_ctrl); // [R11] [R25]
	end

	always_comb begin
		st_next = st_reg;
		// Register writes; the status register ignores them
		if (reg_req.sel && reg_req.wr) begin // [R18]
			case (reg_req.addr)
				`ADDR_LEVEL_MASK: st_next.level_mask = reg_req.wdata; // [R8]
				`ADDR_SYS_MODE: st_next.system_mode_ctrl =
					reg_req.wdata & `MODE_USED_MASK; // [R5] [R6]
				`ADDR_LEVEL_PRIO: st_next.level_priority_ctrl = reg_req.wdata;
				default: st_next.level_mask = st_reg.level_mask;
			endcase
		end
		// Instructions outrank a write in the same cycle
		if (cpu_ctl.ack) begin
			st_next.system_mode_ctrl[`MODE_GLOBAL_EN] = 1'b0; // [R21]
		end
		if (cpu_ctl.disable_interrupts_instr) begin
			st_next.system_mode_ctrl[`MODE_GLOBAL_EN] = 1'b0; // [R6]
		end
		if (cpu_ctl.enable_interrupts_instr ||
			cpu_ctl.interrupt_return_instr) begin
			st_next.system_mode_ctrl[`MODE_GLOBAL_EN] = 1'b1; // [R6] [R22]
		end
		// Acknowledge clears an overflow or counter pending; new event wins
		if (cpu_ctl.ack && st_reg.irq.valid && !st_reg.irq.level[2] &&
			st_reg.irq.source == `SRC_OVF) begin
			st_next.hw_pend[st_reg.irq.level[1:0]] = 1'b0; // [R2] [R20] [R24]
		end
		st_next.hw_pend = st_next.hw_pend | hw_event; // [R24]
		// Status shows requests whatever the global enable [R17] [R19]
		st_next.level_request_status = level_req;
		// Resolved request to the CPU
		st_next.irq.valid = win[3] &&
			st_reg.system_mode_ctrl[`MODE_GLOBAL_EN]; // [R19] [R21]
		st_next.irq.level = win[2:0];
		st_next.irq.source = source_of(win[2:0], hw_act, sw_act); // [R11]
		st_next.irq.fast = win[3] &&
			st_reg.system_mode_ctrl[`MODE_FAST_EN] &&
			st_reg.system_mode_ctrl[`MODE_FAST_HI:`MODE_FAST_LO] ==
			win[2:0]; // [R5] [R23]
		// Read data
		case (reg_req.addr)
			`ADDR_REQ_STATUS: st_next.rdata = st_reg.level_request_status;
			`ADDR_LEVEL_MASK: st_next.rdata = st_reg.level_mask;
			`ADDR_SYS_MODE: st_next.rdata = st_reg.system_mode_ctrl;
			`ADDR_LEVEL_PRIO: st_next.rdata = st_reg.level_priority_ctrl;
			default: st_next.rdata = `RST_BYTE;
		endcase
		if (!reg_req.sel) begin
			st_next.rdata = `RST_BYTE;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_reg.level_mask <= `RST_BYTE;
			st_reg.system_mode_ctrl <= `RST_BYTE; // [R4]
			st_reg.level_priority_ctrl <= `RST_BYTE;
			st_reg.level_request_status <= `RST_BYTE; // [R18]
			st_reg.hw_pend <= `RST_HW_PEND;
			st_reg.rdata <= `RST_BYTE;
			st_reg.irq <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign irq = st_reg.irq;

	// Checks
	enable_instr_sets_a: assert property (@(posedge clk_sys) // [R6]
		disable iff (!rst_b)
		cpu_ctl.enable_interrupts_instr |=>
		st_reg.system_mode_ctrl[`MODE_GLOBAL_EN])
		else $error("enable instruction did not set global enable");

	disable_instr_clears_a: assert property (@(posedge clk_sys) // [R6]
		disable iff (!rst_b)
		(cpu_ctl.disable_interrupts_instr &&
		!cpu_ctl.enable_interrupts_instr &&
		!cpu_ctl.interrupt_return_instr) |=>
		!st_reg.system_mode_ctrl[`MODE_GLOBAL_EN])
		else $error("disable instruction left global enable set");

	return_sets_enable_a: assert property (@(posedge clk_sys) // [R22]
		disable iff (!rst_b)
		cpu_ctl.interrupt_return_instr |=>
		st_reg.system_mode_ctrl[`MODE_GLOBAL_EN])
		else $error("interrupt return did not restore global enable");

	ack_clears_enable_a: assert property (@(posedge clk_sys) // [R21]
		disable iff (!rst_b)
		(cpu_ctl.ack && !cpu_ctl.enable_interrupts_instr &&
		!cpu_ctl.interrupt_return_instr) |=>
		!st_reg.system_mode_ctrl[`MODE_GLOBAL_EN])
		else $error("acknowledge left global enable set");

	status_tracks_req_a: assert property (@(posedge clk_sys) // [R17]
		disable iff (!rst_b)
		##1 st_reg.level_request_status == $past(level_req))
		else $error("status register does not follow level requests");

	status_write_ignored_a: assert property (@(posedge clk_sys) // [R18]
		disable iff (!rst_b)
		(reg_req.sel && reg_req.wr && reg_req.addr == `ADDR_REQ_STATUS &&
		level_req == st_reg.level_request_status) |=>
		$stable(st_reg.level_request_status))
		else $error("write changed the request status register");

	idle_read_zero_a: assert property (@(posedge clk_sys) // [R18]
		disable iff (!rst_b)
		!reg_req.sel |=> reg_rdata == `RST_BYTE)
		else $error("read data not zero without an access");

	mask_write_lands_a: assert property (@(posedge clk_sys) // [R8]
		disable iff (!rst_b)
		(reg_req.sel && reg_req.wr &&
		reg_req.addr == `ADDR_LEVEL_MASK) |=>
		st_reg.level_mask == $past(reg_req.wdata))
		else $error("mask write did not land");

	prio_write_lands_a: assert property (@(posedge clk_sys) // [R13]
		disable iff (!rst_b)
		(reg_req.sel && reg_req.wr &&
		reg_req.addr == `ADDR_LEVEL_PRIO) |=>
		st_reg.level_priority_ctrl == $past(reg_req.wdata))
		else $error("priority write did not land");

	masked_no_serve_a: assert property (@(posedge clk_sys) // [R8] [R19]
		disable iff (!rst_b)
		irq.valid |-> $past(st_reg.level_mask[win[2:0]]) &&
		$past(st_reg.system_mode_ctrl[`MODE_GLOBAL_EN]))
		else $error("masked or globally disabled level offered");

	valid_has_req_a: assert property (@(posedge clk_sys) // [R25]
		disable iff (!rst_b)
		irq.valid |-> |($past(serve_req) & (8'h01 << irq.level)))
		else $error("offered level has no unmasked request");

	fast_needs_enable_a: assert property (@(posedge clk_sys) // [R23]
		disable iff (!rst_b)
		irq.fast |-> $past(st_reg.system_mode_ctrl[`MODE_FAST_EN]) &&
		$past(st_reg.system_mode_ctrl[`MODE_FAST_HI:`MODE_FAST_LO]) ==
		irq.level)
		else $error("fast flag without fast enable or wrong level");

	fast_disabled_off_a: assert property (@(posedge clk_sys) // [R23]
		disable iff (!rst_b)
		!st_reg.system_mode_ctrl[`MODE_FAST_EN] |=> !irq.fast)
		else $error("fast flag while fast processing is off");

	hw_ack_clear_a: assert property (@(posedge clk_sys) // [R24]
		disable iff (!rst_b)
		(cpu_ctl.ack && irq.valid && irq.level == 3'h0 &&
		irq.source == `SRC_OVF && !hw_event[`HW_T0_OVF]) |=>
		!st_reg.hw_pend[`HW_T0_OVF])
		else $error("acknowledged overflow pending not cleared");

	hw_event_sets_a: assert property (@(posedge clk_sys) // [R2]
		disable iff (!rst_b)
		|hw_event |=>
		(st_reg.hw_pend & $past(hw_event)) == $past(hw_event))
		else $error("hardware event did not set its pending");

	event_wins_a: assert property (@(posedge clk_sys) // [R2]
		disable iff (!rst_b)
		hw_event[`HW_CNT_A] |=> st_reg.hw_pend[`HW_CNT_A] ##1
		(st_reg.level_request_status[2] || !$past(hw_enable[`HW_CNT_A])))
		else $error("counter event lost or not shown in status");

	group_order_a: assert property (@(posedge clk_sys) // [R13]
		disable iff (!rst_b)
		(st_reg.level_priority_ctrl[`PRIO_GRP_HI] &&
		!st_reg.level_priority_ctrl[`PRIO_GRP_MID] &&
		st_reg.level_priority_ctrl[`PRIO_GRP_LO] &&
		serve_req[2] && |serve_req[7:5]) |-> win[2:0] >= 3'h5)
		else $error("group C did not outrank group B");

	level_one_first_a: assert property (@(posedge clk_sys) // [R16]
		disable iff (!rst_b)
		(&serve_req[1:0] && st_reg.level_priority_ctrl[`PRIO_LVL01] &&
		st_reg.level_priority_ctrl[`PRIO_GRP_HI] &&
		st_reg.level_priority_ctrl[`PRIO_GRP_MID]) |-> win[2:0] == 3'h1)
		else $error("level 1 did not outrank level 0");

endmodule

`default_nettype wire

// ---- verif/periph_src_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Peripheral pending flags that only software clears
module periph_src_model
	import level_irq_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Set and software clear strobes
	input wire sw_src_t set_req,
	input wire sw_src_t clr_req,
	// Pending levels to the controller
	output sw_src_t sw_pend
);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			sw_pend <= '0;
		else
			sw_pend <= (sw_pend & ~clr_req) | set_req;
	end
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "level_irq_cfg.svh"
module tb_top
	import level_irq_pkg::*;
;
	logic clk_sys, rst_b;
	reg_req_t reg_req;
	logic [7:0] reg_rdata, mask_m, prio_m, mode_m, rd;
	cpu_ctl_t cpu_ctl;
	irq_out_t irq;
	logic [3:0] hw_event, hw_en, hwp;
	sw_src_t sw_pend, sw_en, set_req, clr_req, sw_m;
	int n_errors, tests_run, seed;
	logic [7:0] adr[5] = '{`ADDR_REQ_STATUS, `ADDR_LEVEL_MASK,
		`ADDR_SYS_MODE, `ADDR_LEVEL_PRIO, 8'h10};

	periph_src_model u_src(.clk_sys(clk_sys), .rst_b(rst_b),
		.set_req(set_req), .clr_req(clr_req), .sw_pend(sw_pend));
	level_interrupt_controller u_dut(.clk_sys(clk_sys), .rst_b(rst_b),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .cpu_ctl(cpu_ctl),
		.irq(irq), .hw_event(hw_event), .hw_enable(hw_en),
		.sw_pend(sw_pend), .sw_enable(sw_en));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Expected status and offered request
	function automatic void calc(output logic [7:0] st, output irq_out_t x);
		sw_src_t e;
		logic [3:0] h, nb;
		logic [7:0] m;
		int a[$], b[$], c[$], s[$], o[$];
		e = sw_m & sw_en;
		h = hwp & hw_en;
		st = {|e.port0[7:4], |e.port0[3:0], |e.port2[7:4], |e.port2[3:0],
			h[3] | e.tmr_match[2], h[2], h[1] | e.tmr_match[1],
			h[0] | e.tmr_match[0]};
		m = st & mask_m;
		if (prio_m[0]) a = '{1, 0}; else a = '{0, 1};
		if (prio_m[3]) s = '{4, 3}; else s = '{3, 4};
		if (prio_m[2]) b = {s, 2}; else b = {2, s};
		if (prio_m[5]) c = '{7, 6, 5}; else c = '{5, 6, 7};
		case ({prio_m[7], prio_m[4], prio_m[1]})
			3'b001: o = {b, c, a};
			3'b010: o = {a, c, b};
			3'b011: o = {b, a, c};
			3'b100: o = {c, a, b};
			3'b101: o = {c, b, a};
			default: o = {a, b, c};
		endcase
		x = '0;
		x.valid = mode_m[0] && (m != 8'h00);
		for (int i = 7; i >= 0; i--)
			if (m[o[i]]) x.level = 3'(o[i]);
		case (x.level)
			3'd4: nb = e.port2[3:0];
			3'd5: nb = e.port2[7:4];
			3'd6: nb = e.port0[3:0];
			3'd7: nb = e.port0[7:4];
			default: nb = {2'h0, 1'b1, h[x.level[1:0]]};
		endcase
		for (int k = 3; k >= 0; k--)
			if (nb[k]) x.source = 2'(k);
		x.fast = mode_m[1] && (x.level == mode_m[4:2]);
	endfunction

	function automatic logic [7:0] mdl(logic [7:0] a);
		logic [7:0] st;
		irq_out_t x;
		calc(st, x);
		case (a)
			`ADDR_REQ_STATUS: return st;
			`ADDR_LEVEL_MASK: return mask_m;
			`ADDR_SYS_MODE: return mode_m;
			`ADDR_LEVEL_PRIO: return prio_m;
			default: return 8'h00;
		endcase
	endfunction

	task automatic cmp8(logic [7:0] got, logic [7:0] exp, string s);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
		end
	endtask

	task automatic acc(logic wr, logic [7:0] a, logic [7:0] d);
		@(posedge clk_sys);
		reg_req <= '{1'b1, wr, a, d};
		if (wr && a == `ADDR_LEVEL_MASK) mask_m = d;
		if (wr && a == `ADDR_LEVEL_PRIO) prio_m = d;
		if (wr && a == `ADDR_SYS_MODE) mode_m = d & `MODE_USED_MASK;
		@(posedge clk_sys);
		reg_req <= '0;
		#1 rd = reg_rdata;
	endtask

	task automatic regs_all();
		foreach (adr[i]) begin
			acc(1'b0, adr[i], 8'h00);
			cmp8(rd, mdl(adr[i]), "register read");
		end
	endtask

	task automatic cpu(cpu_ctl_t c);
		logic [7:0] st;
		irq_out_t x;
		calc(st, x);
		@(posedge clk_sys);
		cpu_ctl <= c;
		if (c.ack && x.valid && x.level < 3'd4 && x.source == 2'h0)
			hwp[x.level[1:0]] = 1'b0;
		if (c.disable_interrupts_instr || c.ack) mode_m[0] = 1'b0;
		if (c.enable_interrupts_instr || c.interrupt_return_instr)
			mode_m[0] = 1'b1;
		@(posedge clk_sys);
		cpu_ctl <= '0;
	endtask

	task automatic src(sw_src_t s, sw_src_t c);
		@(posedge clk_sys);
		set_req <= s;
		clr_req <= c;
		sw_m = (sw_m & ~c) | s;
		@(posedge clk_sys);
		set_req <= '0;
		clr_req <= '0;
	endtask

	task automatic hwev(logic [3:0] e);
		@(posedge clk_sys);
		hw_event <= e;
		hwp = hwp | e;
		@(posedge clk_sys);
		hw_event <= '0;
	endtask

	task automatic check();
		logic [7:0] st;
		irq_out_t x;
		repeat (4) @(posedge clk_sys);
		calc(st, x);
		acc(1'b0, `ADDR_REQ_STATUS, 8'h00);
		cmp8(rd, st, "status");
		tests_run++;
		if (irq.valid !== x.valid || (x.valid && irq !== x)) begin
			n_errors++;
			$display("mismatch at %0t: irq %h exp %h", $time, irq, x);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#400000;
		n_errors++;
		$display("mismatch at %0t: run limit reached", $time);
		print_verdict();
	end

	initial begin
		seed = 32'h52807448;
		{rst_b, reg_req, cpu_ctl, hw_event, set_req, clr_req, sw_m} = '0;
		{hwp, mask_m, prio_m, mode_m, n_errors, tests_run} = '0;
		hw_en = '1;
		sw_en = '1;
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		regs_all();
		for (int r = 0; r < 2; r++) begin
			foreach (adr[i]) acc(1'b1, adr[i], 8'($random(seed)) | 8'h60);
			regs_all();
		end
		$display("test registers done");
		acc(1'b1, `ADDR_LEVEL_MASK, 8'hFF);
		acc(1'b1, `ADDR_LEVEL_PRIO, 8'h00);
		acc(1'b1, `ADDR_SYS_MODE, 8'h00);
		cpu(4'b1000);
		for (int i = 0; i < 19; i++) begin
			src(19'h1 << i, '0);
			check();
			src('0, '1);
		end
		for (int i = 0; i < 4; i++) begin
			hwev(4'h1 << i);
			check();
			cpu(4'b0001);
			check();
			if (i[0]) cpu(4'b1000);
			else acc(1'b1, `ADDR_SYS_MODE, 8'h01);
		end
		$display("test mapping done");
		for (int p = 0; p < 256; p++) begin
			acc(1'b1, `ADDR_SYS_MODE, 8'($random(seed)) & 8'hFE);
			acc(1'b1, `ADDR_LEVEL_PRIO, 8'(p));
			acc(1'b1, `ADDR_LEVEL_MASK, 8'($random(seed)));
			src(19'($random(seed)), '1);
			@(posedge clk_sys);
			hw_en <= 4'($random(seed));
			sw_en <= 19'($random(seed));
			hwev(4'($random(seed)));
			check();
			cpu(4'b1000);
			check();
		end
		$display("test priority done");
		acc(1'b1, `ADDR_LEVEL_MASK, 8'hFF);
		@(posedge clk_sys);
		hw_en <= '1;
		sw_en <= '1;
		src(19'h10000, '1);
		hwev(4'h1);
		check();
		cpu(4'b0001);
		check();
		cpu(4'b0010);
		check();
		cpu(4'b0001);
		src('0, 19'h10000);
		cpu(4'b0010);
		check();
		$display("test acknowledge done");
		print_verdict();
	end
endmodule
`default_nettype wire
